// >>> core/qpwm_pkg.sv
// Purpose: Shared constants for the four channel PWM block.
// Assumes: 250 MHz reference clock, word registers on a plain port.
// Notes: Register map, command fields and clock constants below.
package qpwm_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned PORT_D_W = 6;
  localparam int unsigned PIN_BASE = 2;
  // Register map, word addresses.
  localparam logic [ADDR_W-1:0] ADDR_COMMAND = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_LOAD = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h2;
  localparam logic [CNT_W-1:0] LOAD_RESET = 24'h000000;
  // Command byte fields.
  localparam int unsigned OPCODE_MSB = 7;
  localparam int unsigned OPCODE_LSB = 4;
  localparam int unsigned SEL_MSB = 3;
  localparam int unsigned SEL_LSB = 1;
  localparam int unsigned FLAG_BIT = 0;
  localparam logic [3:0] OP_STOP = 4'h0;
  localparam logic [3:0] OP_LOAD = 4'h1;
  localparam logic [3:0] OP_POLARITY = 4'h2;
  localparam logic [3:0] OP_OUT_EN = 4'h3;
  localparam logic [3:0] OP_CLEAR = 4'h4;
  localparam logic [3:0] OP_ROUTE = 4'h5;
  localparam logic [3:0] OP_CLK_SEL = 4'h6;
  localparam logic [3:0] OP_START = 4'h7;
  // Status register fields.
  localparam int unsigned ST_RUN_LSB = 0;
  localparam int unsigned ST_WAVE_LSB = 4;
  localparam int unsigned ST_ROUTE_LSB = 8;
  localparam int unsigned ST_PIN_LSB = 12;
  // Counting clocks derived from the reference.
  localparam int unsigned REF_CLK_HZ = 250_000_000;
  localparam int unsigned FAST_CLK_HZ = 50_000_000;
  localparam int unsigned SLOW_CLK_HZ = 1_000_000;
  localparam int unsigned FAST_DIV = REF_CLK_HZ / FAST_CLK_HZ;
  localparam int unsigned SLOW_DIV = REF_CLK_HZ / SLOW_CLK_HZ;
  localparam int unsigned DIV_W = 8;
endpackage : qpwm_pkg

// >>> core/qpwm_channel.sv
// Purpose: One PWM channel with its counters and settings.
// Assumes: Commands arrive as a one cycle hit with opcode and flag.
// Notes: Output is registered; polarity applied after gating.
`timescale 1ns/1ps
module qpwm_channel
  import qpwm_pkg::*;
#(
  parameter int unsigned W = CNT_W
) (
  input wire logic ref_clk_i, // Reference clock.
  input wire logic resetn_i, // Async reset, active low.
  input wire logic cmd_hit_i, // Command addresses this channel.
  input wire logic [3:0] cmd_op_i, // Command opcode.
  input wire logic cmd_flag_i, // Command flag.
  input wire logic [W-1:0] load_value_i, // Load value register.
  input wire logic tick_fast_i, // 50 MHz counting pulse.
  input wire logic tick_slow_i, // 1 MHz counting pulse.
  output logic wave_o, // Channel output level.
  output logic running_o, // Channel is running.
  output logic route_o // Channel routed to port D.
);
  logic [W-1:0] period_init_q, duty_init_q;
  logic [W-1:0] period_cnt_q, duty_cnt_q;
  logic running_q, pol_q, out_en_q, route_q, slow_q, wave_q;
  logic tick, active;

  assign tick = slow_q ? tick_slow_i : tick_fast_i;
  assign active = running_q && (duty_cnt_q != '0);

  // ---------------------------------------------
  // Settings
  // ---------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      period_init_q <= '0;
      duty_init_q <= '0;
      pol_q <= 1'b0;
      out_en_q <= 1'b0;
      route_q <= 1'b0;
      slow_q <= 1'b0;
    end else if (cmd_hit_i) begin
      unique case (cmd_op_i)
        OP_LOAD: begin
          if (cmd_flag_i) duty_init_q <= load_value_i;
          else period_init_q <= load_value_i;
        end
        OP_POLARITY: pol_q <= cmd_flag_i;
        OP_OUT_EN: out_en_q <= cmd_flag_i;
        OP_ROUTE: route_q <= cmd_flag_i;
        OP_CLK_SEL: slow_q <= cmd_flag_i;
        OP_CLEAR: begin
          period_init_q <= '0;
          duty_init_q <= '0;
          pol_q <= 1'b0;
          out_en_q <= 1'b0;
          route_q <= 1'b0;
          slow_q <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------
  // Counters
  // ---------------------------------------------
  // Reload happens on the tick that would bring the period to zero, so a
  // duty equal to the period never shows an inactive tick at the seam.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      running_q <= 1'b0;
      period_cnt_q <= '0;
      duty_cnt_q <= '0;
    end else if (cmd_hit_i && cmd_op_i == OP_START) begin
      running_q <= 1'b1;
      period_cnt_q <= period_init_q;
      duty_cnt_q <= duty_init_q;
    end else if (cmd_hit_i && (cmd_op_i == OP_STOP || cmd_op_i == OP_CLEAR)) begin
      running_q <= 1'b0;
      period_cnt_q <= '0;
      duty_cnt_q <= '0;
    end else if (running_q && tick) begin
      if (period_cnt_q <= W'(1)) begin
        period_cnt_q <= period_init_q;
        duty_cnt_q <= duty_init_q;
      end else begin
        period_cnt_q <= period_cnt_q - W'(1);
        if (duty_cnt_q != '0) duty_cnt_q <= duty_cnt_q - W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) wave_q <= 1'b0;
    else wave_q <= (out_en_q && active) ^ pol_q;
  end

  assign wave_o = wave_q;
  assign running_o = running_q;
  assign route_o = route_q;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  chk_inactive_level: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !(out_en_q && active) |=> wave_q == $past(pol_q))
    else $error("gated or idle channel not at inactive level");
  chk_active_level: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (out_en_q && active) |=> wave_q == !$past(pol_q))
    else $error("active channel not at active level");
  chk_period_reload: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (running_q && tick && period_cnt_q <= W'(1) && !cmd_hit_i)
    |=> period_cnt_q == $past(period_init_q) && duty_cnt_q == $past(duty_init_q))
    else $error("counters did not reload at period end");
  chk_duty_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (running_q && duty_cnt_q == '0 && period_cnt_q > W'(1) && !cmd_hit_i) |=> duty_cnt_q == '0)
    else $error("duty counter moved after reaching zero");
  chk_full_duty: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (running_q && duty_init_q == period_init_q && duty_cnt_q == period_cnt_q
     && duty_cnt_q != '0 && !cmd_hit_i) |=> duty_cnt_q != '0)
    else $error("full duty channel went inactive");
  chk_start_load: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (cmd_hit_i && cmd_op_i == OP_START) |=> running_q && period_cnt_q == $past(period_init_q))
    else $error("start did not load counters");
  chk_clear_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (cmd_hit_i && cmd_op_i == OP_CLEAR) |=> !running_q && period_init_q == '0 && !route_q)
    else $error("clear left state behind");
endmodule : qpwm_channel

// >>> core/qpwm_top.sv
// Purpose: Four channel PWM block with command port and port D override.
// Assumes: Bus strobes are one cycle, never both at once.
// Notes: Command register is write only and reads as zero.
`timescale 1ns/1ps
module qpwm_top
  import qpwm_pkg::*;
#(
  parameter int unsigned CH = NUM_CH,
  parameter int unsigned W = CNT_W
) (
  input wire logic ref_clk_i, // 250 MHz reference clock.
  input wire logic resetn_i, // Async reset, active low.
  input wire logic [ADDR_W-1:0] addr_i, // Register word address.
  input wire logic [31:0] wdata_i, // Write data.
  input wire logic we_i, // Write strobe.
  input wire logic re_i, // Read strobe.
  output logic [31:0] rdata_o, // Read data, cycle after re_i.
  input wire logic [PORT_D_W-1:0] port_d_direction_bit_i, // Port D direction, 1 = out.
  input wire logic [PORT_D_W-1:0] port_d_data_i, // Port D output register.
  input wire logic [PORT_D_W-1:0] port_d_pin_i, // Port D pin level in.
  output logic [PORT_D_W-1:0] port_d_pin_o, // Port D pin level out.
  output logic [PORT_D_W-1:0] port_d_pin_oe_n_o // Port D enable, low drives.
);
  // ---------------------------------------------
  // Registers and command decode
  // ---------------------------------------------
  logic [W-1:0] load_q;
  logic cmd_stb;
  logic [3:0] cmd_op;
  logic [2:0] cmd_sel;
  logic cmd_flag;
  logic cmd_all;
  logic [CH-1:0] cmd_hit;
  logic [CH-1:0] wave, running, route;
  logic [31:0] rdata_q;
  logic [PORT_D_W-1:0] pin_q, oe_n_q;

  assign cmd_stb = we_i && (addr_i == ADDR_COMMAND);
  assign cmd_op = wdata_i[OPCODE_MSB:OPCODE_LSB];
  assign cmd_sel = wdata_i[SEL_MSB:SEL_LSB];
  assign cmd_flag = wdata_i[FLAG_BIT];

  // The all-channel flag sense is inverted for stop only.
  always_comb begin
    unique case (cmd_op)
      OP_STOP: cmd_all = !cmd_flag;
      OP_CLEAR: cmd_all = cmd_flag;
      OP_START: cmd_all = cmd_flag;
      default: cmd_all = 1'b0;
    endcase
  end

  // Select codes at or above the channel count address no channel.
  always_comb begin
    for (int k = 0; k < CH; k++) begin
      cmd_hit[k] = cmd_stb && (cmd_all || (32'(cmd_sel) == k));
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) load_q <= LOAD_RESET;
    else if (we_i && addr_i == ADDR_LOAD) load_q <= wdata_i[W-1:0];
  end

  // ---------------------------------------------
  // Counting clock pulses
  // ---------------------------------------------
  // Both rates come from one reference, so channels on the same rate tick
  // together and no second clock domain is needed.
  logic [DIV_W-1:0] fast_cnt_q, slow_cnt_q;
  logic tick_fast, tick_slow;

  assign tick_fast = (fast_cnt_q == DIV_W'(FAST_DIV - 1));
  assign tick_slow = (slow_cnt_q == DIV_W'(SLOW_DIV - 1));

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) fast_cnt_q <= '0;
    else if (tick_fast) fast_cnt_q <= '0;
    else fast_cnt_q <= fast_cnt_q + DIV_W'(1);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) slow_cnt_q <= '0;
    else if (tick_slow) slow_cnt_q <= '0;
    else slow_cnt_q <= slow_cnt_q + DIV_W'(1);
  end

  // ---------------------------------------------
  // Channels
  // ---------------------------------------------
  for (genvar g = 0; g < CH; g++) begin : g_ch
    qpwm_channel #(
      .W(W)
    ) u_ch (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .cmd_hit_i(cmd_hit[g]),
      .cmd_op_i(cmd_op),
      .cmd_flag_i(cmd_flag),
      .load_value_i(load_q),
      .tick_fast_i(tick_fast),
      .tick_slow_i(tick_slow),
      .wave_o(wave[g]),
      .running_o(running[g]),
      .route_o(route[g])
    );
  end

  // ---------------------------------------------
  // Port D pin override
  // ---------------------------------------------
  // A routed pin drives whatever the channel shows; with its output gated
  // that is the inactive level, so routing alone parks the pin safely.
  // Channel signals are first placed on pin positions, so that no pin
  // outside the channel range ever indexes a channel.
  logic [PORT_D_W-1:0] route_pin, wave_pin;

  always_comb begin
    route_pin = '0;
    wave_pin = '0;
    route_pin[PIN_BASE +: CH] = route;
    wave_pin[PIN_BASE +: CH] = wave;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_q <= '0;
      oe_n_q <= '1;
    end else begin
      for (int n = 0; n < PORT_D_W; n++) begin
        if (route_pin[n]) begin
          pin_q[n] <= wave_pin[n];
          oe_n_q[n] <= 1'b0;
        end else begin
          pin_q[n] <= port_d_data_i[n];
          oe_n_q[n] <= !port_d_direction_bit_i[n];
        end
      end
    end
  end

  assign port_d_pin_o = pin_q;
  assign port_d_pin_oe_n_o = oe_n_q;

  // ---------------------------------------------
  // Read port
  // ---------------------------------------------
  logic [31:0] status;

  always_comb begin
    status = '0;
    status[ST_RUN_LSB +: CH] = running;
    status[ST_WAVE_LSB +: CH] = wave;
    status[ST_ROUTE_LSB +: CH] = route;
    status[ST_PIN_LSB +: PORT_D_W] = port_d_pin_i;
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= '0;
    end else if (re_i) begin
      unique case (addr_i)
        ADDR_LOAD: rdata_q <= {{(32 - W){1'b0}}, load_q};
        ADDR_STATUS: rdata_q <= status;
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign rdata_o = rdata_q;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  chk_stop_all: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (we_i && addr_i == ADDR_COMMAND && wdata_i[7:0] == 8'h00) |=> running == '0)
    else $error("stop all left a channel running");
  chk_start_all: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (we_i && addr_i == ADDR_COMMAND && wdata_i[7:0] == 8'h7f) |=> running == '1)
    else $error("start all missed a channel");
  chk_load_read: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (we_i && addr_i == ADDR_LOAD) ##1 !(we_i && addr_i == ADDR_LOAD) ##1 (re_i && addr_i == ADDR_LOAD)
    |=> rdata_o == {{(32 - W){1'b0}}, $past(wdata_i[W-1:0], 3)})
    else $error("load value did not read back");
  chk_route_drive: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    route[0] |=> !port_d_pin_oe_n_o[PIN_BASE] && port_d_pin_o[PIN_BASE] == $past(wave[0]))
    else $error("routed pin not driven by its channel");
  chk_unrouted_pin: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !route[CH-1] |=> port_d_pin_oe_n_o[PIN_BASE+CH-1] == !$past(port_d_direction_bit_i[PIN_BASE+CH-1]))
    else $error("unrouted pin ignores its direction bit");
endmodule : qpwm_top

// >>> testbench/qpwm_port_model.sv
// Purpose: External equipment on the port D pins, resolving each pin's level.
// Assumes: Low enable means the block drives the pin.
// Notes: A released pin shows the inverse of its last level, so no stale value passes.
`timescale 1ns/1ps
module qpwm_port_model (
  input wire logic ref_clk_i, // Reference clock.
  input wire logic [5:0] pin_o_i, // Level driven by the block.
  input wire logic [5:0] pin_oe_n_i, // Block enable, low drives.
  output logic [5:0] pin_level_o // Resolved pin level.
);
  logic [5:0] last_q = 6'h00;
  // ----------------------------------------
  // Pin resolution
  // ----------------------------------------
  // An undriven pin toggles every cycle because the simulator would otherwise pick a level by itself.
  always_comb begin
    for (int b = 0; b < 6; b++) begin
      pin_level_o[b] = pin_oe_n_i[b] ? ~last_q[b] : pin_o_i[b];
    end
  end
  always_ff @(posedge ref_clk_i) begin
    last_q <= pin_level_o;
  end
endmodule : qpwm_port_model

// >>> testbench/qpwm_top_tb.sv
// Purpose: Self-checking bench for the four channel PWM block.
// Assumes: Reads answer one cycle after the strobe; ticks every 5 or 250 clocks.
// Notes: Pulse widths are counted over windows that hold a whole number of periods.
`timescale 1ns/1ps
module qpwm_top_tb;
  import qpwm_pkg::*;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic re_d = 1'b0;
  logic [31:0] rdata;
  logic [5:0] dir = '0;
  logic [5:0] dat = '0;
  logic [5:0] pin_lvl;
  logic [5:0] pin_o;
  logic [5:0] oe_n;
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];
  int mismatches = 0;
  int checks = 0;
  int hi[4];
  logic [31:0] v;
  always #2 ref_clk_i = ~ref_clk_i;
  qpwm_top i_qpwm_top (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr), .wdata_i(wdata),
    .we_i(we), .re_i(re), .rdata_o(rdata), .port_d_direction_bit_i(dir), .port_d_data_i(dat),
    .port_d_pin_i(pin_lvl), .port_d_pin_o(pin_o), .port_d_pin_oe_n_o(oe_n));
  qpwm_port_model i_qpwm_port_model (.ref_clk_i(ref_clk_i), .pin_o_i(pin_o), .pin_oe_n_i(oe_n),
    .pin_level_o(pin_lvl));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge ref_clk_i);
    we <= 1'b0;
  endtask : wr
  task automatic cmd(input logic [3:0] op, input logic [2:0] ch, input logic f);
    wr(ADDR_COMMAND, {24'h000000, op, ch, f});
  endtask : cmd
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    @(posedge ref_clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge ref_clk_i);
    re <= 1'b0;
  endtask : rd
  task automatic meas(input int n);
    hi = '{default: 0};
    repeat (n) begin
      @(negedge ref_clk_i);
      for (int b = 0; b < 4; b++) begin
        if (pin_o[b+2] === 1'b1) hi[b]++;
      end
    end
  endtask : meas
  task automatic results();
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  // ----------------------------------------
  // Read monitor
  // ----------------------------------------
  always @(posedge ref_clk_i) re_d <= re;
  always @(negedge ref_clk_i) begin
    if (re_d === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(32'hdeadbeef, rdata);
      end else begin
        chk(exp_q.pop_front(), rdata & mask_q.pop_front());
      end
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h4fdf));
    dir <= 6'($urandom);
    dat <= 6'($urandom);
    repeat (8) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rd(ADDR_LOAD, 32'h0, 32'hffffffff);
    rd(ADDR_COMMAND, 32'h0, 32'hffffffff);
    rd(4'hf, 32'h0, 32'hffffffff);
    rd(ADDR_STATUS, 32'h0, 32'h00000fff);
    v = $urandom;
    wr(ADDR_LOAD, v);
    rd(ADDR_LOAD, v & 32'h00ffffff, 32'hffffffff);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_LOAD, (c == 3) ? 32'h3 : 32'h4);
      cmd(OP_LOAD, 3'(c), 1'b0);
      wr(ADDR_LOAD, 32'(c));
      cmd(OP_LOAD, 3'(c), 1'b1);
      cmd(OP_OUT_EN, 3'(c), 1'b1);
      cmd(OP_ROUTE, 3'(c), 1'b1);
    end
    wr(ADDR_COMMAND, 32'h7f);
    rd(ADDR_STATUS, 32'hf0f, 32'hf0f);
    repeat (40) @(posedge ref_clk_i);
    meas(300);
    chk(32'd0, 32'(hi[0]));
    chk(32'd75, 32'(hi[1]));
    chk(32'd150, 32'(hi[2]));
    chk(32'd300, 32'(hi[3]));
    chk({26'h0, 4'h0, ~dir[1:0]}, {26'h0, oe_n});
    cmd(OP_POLARITY, 3'd1, 1'b1);
    cmd(OP_OUT_EN, 3'd2, 1'b0);
    repeat (40) @(posedge ref_clk_i);
    meas(300);
    chk(32'd225, 32'(hi[1]));
    chk(32'd0, 32'(hi[2]));
    rd(ADDR_STATUS, 32'hf, 32'hf);
    cmd(OP_STOP, 3'd0, 1'b1);
    rd(ADDR_STATUS, 32'he, 32'hf);
    cmd(OP_CLEAR, 3'd1, 1'b0);
    rd(ADDR_STATUS, 32'hd0c, 32'hf0f);
    repeat (3) @(posedge ref_clk_i);
    chk({31'h0, dat[3]}, {31'h0, pin_o[3]});
    chk({31'h0, ~dir[3]}, {31'h0, oe_n[3]});
    cmd(OP_STOP, 3'd0, 1'b0);
    rd(ADDR_STATUS, 32'h0, 32'hf);
    cmd(OP_START, 3'd5, 1'b0);
    cmd(4'h9, 3'd0, 1'b1);
    rd(ADDR_STATUS, 32'h0, 32'hf);
    cmd(OP_START, 3'd2, 1'b0);
    rd(ADDR_STATUS, 32'h4, 32'hf);
    cmd(OP_CLEAR, 3'd0, 1'b1);
    rd(ADDR_STATUS, 32'h0, 32'hf0f);
    repeat (3) @(posedge ref_clk_i);
    chk({26'h0, dat}, {26'h0, pin_o});
    chk({26'h0, ~dir}, {26'h0, oe_n});
    rd(ADDR_STATUS, {14'h0, dat, 12'h0}, {14'h0, dir, 12'h0});
    wr(ADDR_LOAD, 32'h2);
    cmd(OP_LOAD, 3'd0, 1'b0);
    wr(ADDR_LOAD, 32'h1);
    cmd(OP_LOAD, 3'd0, 1'b1);
    cmd(OP_CLK_SEL, 3'd0, 1'b1);
    cmd(OP_OUT_EN, 3'd0, 1'b1);
    cmd(OP_ROUTE, 3'd0, 1'b1);
    cmd(OP_START, 3'd0, 1'b0);
    repeat (1100) @(posedge ref_clk_i);
    meas(1000);
    chk(32'd500, 32'(hi[0]));
    // A second reset in mid-run must drop the written load value and stop the channel.
    @(posedge ref_clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rd(ADDR_LOAD, 32'h0, 32'hffffffff);
    rd(ADDR_STATUS, 32'h0, 32'h00000fff);
    for (int t = 0; t < 20 && exp_q.size() != 0; t++) @(posedge ref_clk_i);
    if (exp_q.size() != 0) begin
      chk(32'h0, 32'(exp_q.size()));
    end
    results();
  end
endmodule : qpwm_top_tb
